// ==== rps_top.sv ====
// Reset pin handling, three general purpose ports and sleep state control behind an AHB-Lite slave.
// Assumes one 50 MHz clock; the reset pin acts asynchronously and needs no clock.
//
// How it works
// - A low reset pin resets the device, even with the clock stopped, unless disabled.
// - With the disable fuse at zero the reset pin works as a plain port pin.
// - Three ports of 8, 4 and 6 bits, each bit with its own pull-up.
// - All port pins float as soon as any reset becomes active, clock or not.
// - Idle halts the processor; timers, ADC, comparator, SPI, TWI and interrupts run.
// - ADC noise reduction halts processor and all I/O except the ADC.
// - Power-down keeps registers, stops everything, wakes only on interrupt or reset.
// - Standby keeps the oscillator running while all else sleeps.
`timescale 1ns/1ps
`default_nettype none
module rps_top
    import rps_pkg::*;
#(
    parameter int PA_W = rps_pkg::RPS_PA_W,
    parameter int PB_W = rps_pkg::RPS_PB_W,
    parameter int PC_W = rps_pkg::RPS_PC_W
) (
    // Clock, reset and enable
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Fuse, core events
    input wire logic reset_pin_disable_fuse_i,
    input wire logic sleep_instr_i,
    input wire logic wake_irq_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    // Ports
    input wire logic [PA_W-1:0] first_port_pins_i,
    output logic [PA_W-1:0] first_port_pins_o,
    output logic [PA_W-1:0] first_port_pins_oe_o,
    output logic [PA_W-1:0] first_port_pull_o,
    input wire logic [PB_W-1:0] second_port_pins_i,
    output logic [PB_W-1:0] second_port_pins_o,
    output logic [PB_W-1:0] second_port_pins_oe_o,
    output logic [PB_W-1:0] second_port_pull_o,
    input wire logic [PC_W-1:0] third_port_pins_i,
    output logic [PC_W-1:0] third_port_pins_o,
    output logic [PC_W-1:0] third_port_pins_oe_o,
    output logic [PC_W-1:0] third_port_pull_o,
    // Reset and clock gating outputs
    output logic chip_rst_o,
    output logic cpu_clk_en_o,
    output logic io_clk_en_o,
    output logic adc_clk_en_o,
    output logic osc_en_o,
    output logic [2:0] sleep_state_o
);

    import rps_pkg::*;

    logic reset_shared_port_pin;
    logic pin_rst;
    logic chip_rst;
    logic [7:0] out_q [RPS_NPORT];
    logic [7:0] out_d [RPS_NPORT];
    logic [7:0] dir_q [RPS_NPORT];
    logic [7:0] dir_d [RPS_NPORT];
    logic [7:0] pull_q [RPS_NPORT];
    logic [7:0] pull_d [RPS_NPORT];
    logic [7:0] in_w [RPS_NPORT];
    logic [7:0] ok_w [RPS_NPORT];
    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    logic ph_q;
    logic ph_d;
    logic ph_wr_q;
    logic ph_wr_d;
    logic [7:0] ph_addr_q;
    logic [7:0] ph_addr_d;
    rps_state_type st_q;
    rps_state_type st_d;
    logic take;
    logic wr_go;
    logic [1:0] pidx;
    logic [3:0] pnum;
    logic [3:0] pofs;
    logic pmapped;
    logic [2:0] mode;

    if (PA_W != RPS_PA_W || PB_W != RPS_PB_W || PC_W != RPS_PC_W) begin : g_chk
        $error("rps_top: port widths must be 8, 4 and 6");
    end

    // The reset pin is sampled without a clock; the pulse length filter is left to the analog pad.
    assign reset_shared_port_pin = third_port_pins_i[RPS_RST_BIT];
    assign pin_rst = reset_pin_disable_fuse_i & ~reset_shared_port_pin;
    assign chip_rst = rst_i | pin_rst;
    assign chip_rst_o = chip_rst;

    // Port pin mapping; the reset-shared pin only acts as a port bit when the fuse is programmed.
    always_comb begin
        ok_w[0] = 8'hff;
        ok_w[1] = 8'hff;
        ok_w[2] = 8'hff;
        ok_w[2][RPS_RST_BIT] = ~reset_pin_disable_fuse_i;
    end

    rps_pad #(.WIDTH(PA_W)) u_pa (
        .clk_sys_i(clk_sys_i), .rst_any_i(chip_rst), .ce_i(ce_i),
        .out_i(out_q[0][PA_W-1:0]), .dir_i(dir_q[0][PA_W-1:0]), .pull_i(pull_q[0][PA_W-1:0]),
        .gpio_ok_i(ok_w[0][PA_W-1:0]), .pin_i(first_port_pins_i), .pin_o(first_port_pins_o),
        .pin_oe_o(first_port_pins_oe_o), .pull_en_o(first_port_pull_o), .in_o(in_w[0][PA_W-1:0])
    );
    rps_pad #(.WIDTH(PB_W)) u_pb (
        .clk_sys_i(clk_sys_i), .rst_any_i(chip_rst), .ce_i(ce_i),
        .out_i(out_q[1][PB_W-1:0]), .dir_i(dir_q[1][PB_W-1:0]), .pull_i(pull_q[1][PB_W-1:0]),
        .gpio_ok_i(ok_w[1][PB_W-1:0]), .pin_i(second_port_pins_i), .pin_o(second_port_pins_o),
        .pin_oe_o(second_port_pins_oe_o), .pull_en_o(second_port_pull_o), .in_o(in_w[1][PB_W-1:0])
    );
    rps_pad #(.WIDTH(PC_W)) u_pc (
        .clk_sys_i(clk_sys_i), .rst_any_i(chip_rst), .ce_i(ce_i),
        .out_i(out_q[2][PC_W-1:0]), .dir_i(dir_q[2][PC_W-1:0]), .pull_i(pull_q[2][PC_W-1:0]),
        .gpio_ok_i(ok_w[2][PC_W-1:0]), .pin_i(third_port_pins_i), .pin_o(third_port_pins_o),
        .pin_oe_o(third_port_pins_oe_o), .pull_en_o(third_port_pull_o), .in_o(in_w[2][PC_W-1:0])
    );
    assign in_w[1][7:PB_W] = '0;
    assign in_w[2][7:PC_W] = '0;

    // Bus front end: zero wait states; the bus is held off while the clock enable is low so no transfer is lost.
    assign take = hsel_i & hready_i & (htrans_i == RPS_HTRANS_NONSEQ) & ce_i;
    assign wr_go = ph_q & ph_wr_q & ce_i;
    assign pnum = ph_addr_q[7:4] - RPS_PORT_BASE[7:4];
    assign pidx = pnum[1:0];
    assign pofs = ph_addr_q[3:0];
    // The whole block number is compared so that addresses above the last port do not alias onto a port.
    assign pmapped = (ph_addr_q >= RPS_PORT_BASE) && (pnum < 4'(RPS_NPORT));
    assign mode = ctrl_q[RPS_CTRL_SM_LSB +: 3];

    always_comb begin
        ph_d = ph_q;
        ph_wr_d = ph_wr_q;
        ph_addr_d = ph_addr_q;
        ctrl_d = ctrl_q;
        out_d = out_q;
        dir_d = dir_q;
        pull_d = pull_q;
        if (ce_i) begin
            ph_d = take;
            ph_wr_d = take & hwrite_i;
            ph_addr_d = take ? haddr_i[7:0] : ph_addr_q;
        end
        if (wr_go) begin
            if (ph_addr_q == RPS_CTRL_ADDR) begin
                ctrl_d = {28'h0, hwdata_i[3:0]};
            end else if (pmapped) begin
                case (pofs)
                    RPS_OFS_OUT: out_d[pidx] = hwdata_i[7:0];
                    RPS_OFS_DIR: dir_d[pidx] = hwdata_i[7:0];
                    RPS_OFS_PULL: pull_d[pidx] = hwdata_i[7:0];
                    default: ;
                endcase
            end
        end
    end

    always_comb begin
        hrdata_o = 32'h0;
        if (ph_q && !ph_wr_q) begin
            if (ph_addr_q == RPS_CTRL_ADDR) begin
                hrdata_o = ctrl_q;
            end else if (ph_addr_q == RPS_STAT_ADDR) begin
                hrdata_o[RPS_STAT_ST_LSB +: 3] = st_q;
                hrdata_o[RPS_STAT_GPIO_BIT] = ~reset_pin_disable_fuse_i;
            end else if (pmapped) begin
                case (pofs)
                    RPS_OFS_OUT: hrdata_o[7:0] = out_q[pidx];
                    RPS_OFS_DIR: hrdata_o[7:0] = dir_q[pidx];
                    RPS_OFS_PULL: hrdata_o[7:0] = pull_q[pidx];
                    RPS_OFS_IN: hrdata_o[7:0] = in_w[pidx];
                    default: hrdata_o = 32'h0;
                endcase
            end
        end
    end
    assign hreadyout_o = ce_i;
    assign hresp_o = 1'b0;

    // Sleep sequencer; registers hold their values in every sleep state.
    always_comb begin
        st_d = st_q;
        if (ce_i) begin
            case (st_q)
                RPS_ST_ACTIVE: begin
                    if (sleep_instr_i && ctrl_q[RPS_CTRL_SE_BIT]) begin
                        case (mode)
                            RPS_SM_IDLE: st_d = RPS_ST_IDLE;
                            RPS_SM_ADCNR: st_d = RPS_ST_ADCNR;
                            RPS_SM_PDOWN: st_d = RPS_ST_PDOWN;
                            RPS_SM_STBY: st_d = RPS_ST_STBY;
                            default: st_d = RPS_ST_ACTIVE;
                        endcase
                    end
                end
                RPS_ST_IDLE, RPS_ST_ADCNR, RPS_ST_PDOWN, RPS_ST_STBY: begin
                    if (wake_irq_i) begin
                        st_d = RPS_ST_ACTIVE;
                    end
                end
                default: st_d = RPS_ST_ACTIVE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge chip_rst) begin
        if (chip_rst) begin
            st_q <= RPS_ST_ACTIVE;
            ctrl_q <= RPS_CTRL_RESET;
            ph_q <= 1'b0;
            ph_wr_q <= 1'b0;
            ph_addr_q <= 8'h00;
            for (int p = 0; p < RPS_NPORT; p++) begin
                out_q[p] <= 8'h00;
                dir_q[p] <= 8'h00;
                pull_q[p] <= 8'h00;
            end
        end else begin
            st_q <= st_d;
            ctrl_q <= ctrl_d;
            ph_q <= ph_d;
            ph_wr_q <= ph_wr_d;
            ph_addr_q <= ph_addr_d;
            out_q <= out_d;
            dir_q <= dir_d;
            pull_q <= pull_d;
        end
    end

    assign cpu_clk_en_o = (st_q == RPS_ST_ACTIVE);
    assign io_clk_en_o = (st_q == RPS_ST_ACTIVE) || (st_q == RPS_ST_IDLE);
    assign adc_clk_en_o = io_clk_en_o || (st_q == RPS_ST_ADCNR);
    assign osc_en_o = (st_q != RPS_ST_PDOWN);
    assign sleep_state_o = st_q;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (chip_rst);

    AST_EXT_RST: assert property (disable iff (rst_i)
        reset_pin_disable_fuse_i && !third_port_pins_i[RPS_RST_BIT] |-> chip_rst_o)
        else $error("Low reset pin did not reset the device.");
    AST_FUSE_GPIO: assert property (disable iff (1'b0)
        !rst_i && !reset_pin_disable_fuse_i |-> !chip_rst_o)
        else $error("Reset pin still resets with fuse programmed.");
    AST_RST_TRI: assert property (disable iff (1'b0)
        chip_rst_o |-> !(|first_port_pins_oe_o) && !(|third_port_pins_oe_o))
        else $error("Port drives during reset.");
    AST_IDLE: assert property (st_q == RPS_ST_IDLE |-> !cpu_clk_en_o && io_clk_en_o && adc_clk_en_o)
        else $error("Idle gating wrong.");
    AST_ADCNR: assert property (st_q == RPS_ST_ADCNR |-> !cpu_clk_en_o && !io_clk_en_o && adc_clk_en_o)
        else $error("ADC noise reduction gating wrong.");
    AST_PDOWN_HOLD: assert property (st_q == RPS_ST_PDOWN && !wake_irq_i ##0 ctrl_q == $past(ctrl_q)
        |=> st_q == RPS_ST_PDOWN && !osc_en_o && !adc_clk_en_o)
        else $error("Power-down left without interrupt or clocks running.");
    AST_WAKE: assert property (st_q != RPS_ST_ACTIVE && wake_irq_i && ce_i |=> cpu_clk_en_o)
        else $error("Interrupt did not wake the device.");
    AST_STBY: assert property (st_q == RPS_ST_STBY |-> osc_en_o && !io_clk_en_o && !cpu_clk_en_o)
        else $error("Standby gating wrong.");
    AST_NO_SE: assert property (cpu_clk_en_o && !ctrl_q[RPS_CTRL_SE_BIT] && ce_i |=> cpu_clk_en_o)
        else $error("Sleep entered without sleep enable.");

    COV_IDLE: cover property (cpu_clk_en_o ##1 st_q == RPS_ST_IDLE ##[1:20] cpu_clk_en_o);
    COV_PDOWN: cover property (st_q == RPS_ST_PDOWN ##[1:20] cpu_clk_en_o);
    COV_STBY: cover property (st_q == RPS_ST_STBY);

endmodule // rps_top
`default_nettype wire

// ==== rps_pkg.sv ====
// Package for the reset pin and sleep control block: register map, field layout and sleep encodings.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package rps_pkg;

    localparam int RPS_NPORT = 3;
    localparam int RPS_PA_W = 8;
    localparam int RPS_PB_W = 4;
    localparam int RPS_PC_W = 6;
    localparam int RPS_RST_BIT = 3;

    localparam logic [7:0] RPS_CTRL_ADDR = 8'h00;
    localparam logic [7:0] RPS_STAT_ADDR = 8'h04;
    localparam logic [7:0] RPS_PORT_BASE = 8'h10;
    localparam logic [7:0] RPS_PORT_STRIDE = 8'h10;
    localparam logic [3:0] RPS_OFS_OUT = 4'h0;
    localparam logic [3:0] RPS_OFS_DIR = 4'h4;
    localparam logic [3:0] RPS_OFS_PULL = 4'h8;
    localparam logic [3:0] RPS_OFS_IN = 4'hc;

    localparam int RPS_CTRL_SE_BIT = 0;
    localparam int RPS_CTRL_SM_LSB = 1;
    localparam int RPS_STAT_ST_LSB = 0;
    localparam int RPS_STAT_GPIO_BIT = 4;
    localparam logic [31:0] RPS_CTRL_RESET = 32'h0000_0000;

    localparam logic [2:0] RPS_SM_IDLE = 3'h0;
    localparam logic [2:0] RPS_SM_ADCNR = 3'h1;
    localparam logic [2:0] RPS_SM_PDOWN = 3'h2;
    localparam logic [2:0] RPS_SM_STBY = 3'h6;

    localparam logic [1:0] RPS_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] RPS_HSIZE_WORD = 3'h2;

    typedef enum logic [2:0] {
        RPS_ST_ACTIVE = 3'b000,
        RPS_ST_IDLE = 3'b001,
        RPS_ST_ADCNR = 3'b010,
        RPS_ST_PDOWN = 3'b011,
        RPS_ST_STBY = 3'b100
    } rps_state_type;

endpackage

// ==== rps_pad.sv ====
// One bidirectional port: drive, tristate and pull-up control for each bit, plus input sampling.
// Assumes pin inputs are synchronous to the clock and that the reset input is the combined chip reset.
`timescale 1ns/1ps
`default_nettype none
module rps_pad #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_any_i,
    input wire logic ce_i,
    // Control from registers
    input wire logic [WIDTH-1:0] out_i,
    input wire logic [WIDTH-1:0] dir_i,
    input wire logic [WIDTH-1:0] pull_i,
    input wire logic [WIDTH-1:0] gpio_ok_i,
    // Pins
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] pin_o,
    output logic [WIDTH-1:0] pin_oe_o,
    output logic [WIDTH-1:0] pull_en_o,
    output logic [WIDTH-1:0] in_o
);

    logic [WIDTH-1:0] in_d;
    logic [WIDTH-1:0] in_q;

    if (WIDTH < 1 || WIDTH > 8) begin : g_chk
        $error("rps_pad: WIDTH must be 1 to 8");
    end

    // Drivers fall to high impedance the moment any reset is asserted, with no clock needed.
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        assign pin_o[i] = out_i[i];
        assign pin_oe_o[i] = dir_i[i] & gpio_ok_i[i] & ~rst_any_i;
        assign pull_en_o[i] = pull_i[i] & ~dir_i[i] & gpio_ok_i[i] & ~rst_any_i;
    end

    always_comb begin
        in_d = ce_i ? pin_i : in_q;
    end

    always_ff @(posedge clk_sys_i or posedge rst_any_i) begin
        if (rst_any_i) begin
            in_q <= '0;
        end else begin
            in_q <= in_d;
        end
    end

    assign in_o = in_q;

    AST_TRI: assert property (@(posedge clk_sys_i) rst_any_i |-> pin_oe_o == '0 && pull_en_o == '0)
        else $error("Port drives or pulls during reset.");
    AST_PULL: assert property (@(posedge clk_sys_i) disable iff (rst_any_i)
        pull_en_o == (pull_i & ~dir_i & gpio_ok_i))
        else $error("Pull-up enable does not follow pull and direction bits.");

endmodule // rps_pad
`default_nettype wire

// ==== rps_board.sv ====
// Board model around one port: outside drivers, line pull-ups and floating lines.
// Assumes the bench chooses which bits an outside party drives and to what level.
`timescale 1ns/1ps
`default_nettype none
module rps_board #(
    parameter int WIDTH = 8
) (
    // Clock
    input wire logic clk_sys_i,
    // Device side of the pins
    input wire logic [WIDTH-1:0] drv_i,
    input wire logic [WIDTH-1:0] oe_i,
    input wire logic [WIDTH-1:0] pull_i,
    // Outside parties
    input wire logic [WIDTH-1:0] ext_en_i,
    input wire logic [WIDTH-1:0] ext_val_i,
    // Resolved line level
    output logic [WIDTH-1:0] pin_o
);
    logic flt_q = 1'b0;

    // A line that nobody drives or pulls shows a level that flips every cycle.
    always_ff @(posedge clk_sys_i) begin
        flt_q <= ~flt_q;
    end

    always_comb begin
        for (int b = 0; b < WIDTH; b++) begin
            if (oe_i[b]) begin
                pin_o[b] = drv_i[b];
            end else if (ext_en_i[b]) begin
                pin_o[b] = ext_val_i[b];
            end else if (pull_i[b]) begin
                pin_o[b] = 1'b1;
            end else begin
                pin_o[b] = flt_q;
            end
        end
    end
endmodule // rps_board
`default_nettype wire

// ==== reset_pin_and_sleep_control_bench.sv ====
// Self-checking bench for the reset pin and sleep control block.
// Assumes a single AHB-Lite master with hready tied to the slave's hreadyout.
`timescale 1ns/1ps
`default_nettype none
module reset_pin_and_sleep_control_bench;
    import rps_pkg::*;
    logic clk_sys_i = 1'b0, rst_i = 1'b1, fuse = 1'b1, sleep_instr = 1'b0, wake_irq = 1'b0;
    logic ce = 1'b1;
    logic hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [7:0] a_in, a_drv, a_oe, a_pull, a_en = 8'h00;
    logic [3:0] b_in, b_drv, b_oe, b_pull, b_en = 4'h0, b_val = 4'h0;
    logic [5:0] c_in, c_drv, c_oe, c_pull, c_en = 6'h08, c_val = 6'h08;
    logic chip_rst, cpu_en, io_en, adc_en, osc_en;
    logic [2:0] state;
    int err_total = 0, comparisons = 0;
    localparam logic [7:0] ROW_A [7] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h24, 8'h38, 8'h4c};
    localparam logic [31:0] ROW_W [7] = '{32'hffffffff, 32'hffffffff, 32'hffffffff, 32'h1a5, 32'hc, 32'h3f,
        32'hffffffff};
    localparam logic [31:0] ROW_E [7] = '{32'hf, 32'h0, 32'h0, 32'ha5, 32'hc, 32'h3f, 32'h0};
    localparam logic [2:0] MODE [4] = '{RPS_SM_IDLE, RPS_SM_ADCNR, RPS_SM_PDOWN, RPS_SM_STBY};
    localparam logic [2:0] ST [4] = '{3'h1, 3'h2, 3'h3, 3'h4};
    localparam logic [3:0] EN [4] = '{4'h7, 4'h3, 4'h0, 4'h1};

    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    rps_top rps_top_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce), .reset_pin_disable_fuse_i(fuse),
        .sleep_instr_i(sleep_instr), .wake_irq_i(wake_irq), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(RPS_HSIZE_WORD), .hwdata_i(hwdata), .hready_i(hreadyout),
        .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata), .first_port_pins_i(a_in),
        .first_port_pins_o(a_drv), .first_port_pins_oe_o(a_oe), .first_port_pull_o(a_pull),
        .second_port_pins_i(b_in), .second_port_pins_o(b_drv), .second_port_pins_oe_o(b_oe),
        .second_port_pull_o(b_pull), .third_port_pins_i(c_in), .third_port_pins_o(c_drv),
        .third_port_pins_oe_o(c_oe), .third_port_pull_o(c_pull), .chip_rst_o(chip_rst), .cpu_clk_en_o(cpu_en),
        .io_clk_en_o(io_en), .adc_clk_en_o(adc_en), .osc_en_o(osc_en), .sleep_state_o(state));
    rps_board #(.WIDTH(8)) rps_board_a_i (.clk_sys_i(clk_sys_i), .drv_i(a_drv), .oe_i(a_oe), .pull_i(a_pull),
        .ext_en_i(a_en), .ext_val_i(8'h00), .pin_o(a_in));
    rps_board #(.WIDTH(4)) rps_board_b_i (.clk_sys_i(clk_sys_i), .drv_i(b_drv), .oe_i(b_oe), .pull_i(b_pull),
        .ext_en_i(b_en), .ext_val_i(b_val), .pin_o(b_in));
    rps_board #(.WIDTH(6)) rps_board_c_i (.clk_sys_i(clk_sys_i), .drv_i(c_drv), .oe_i(c_oe), .pull_i(c_pull),
        .ext_en_i(c_en), .ext_val_i(c_val), .pin_o(c_in));

    task automatic finish_test();
        if (err_total == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge clk_sys_i);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                check("hready_wait", 32'h0, 32'h1);
                finish_test();
            end
            @(posedge clk_sys_i);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_sys_i);
        hsel <= 1'b1;
        htrans <= RPS_HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask

    task automatic sleep_pulse();
        @(posedge clk_sys_i);
        sleep_instr <= 1'b1;
        @(posedge clk_sys_i);
        sleep_instr <= 1'b0;
        #1;
    endtask

    initial begin
        repeat (15) @(posedge clk_sys_i);
        #1;
        check("reset_pins", {5'h0, chip_rst, a_oe, b_oe, c_oe, a_pull}, {5'h0, 1'b1, 26'h0});
        check("reset_state", {b_pull, c_pull, state, cpu_en, io_en, adc_en, osc_en}, {13'h0, 4'hf});
        @(posedge clk_sys_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            bus(1'b1, ROW_A[i], ROW_W[i]);
            bus(1'b0, ROW_A[i], 32'h0);
            check("reg_row", rd, ROW_E[i]);
        end
        a_en <= 8'h0c;
        b_en <= 4'h3;
        b_val <= 4'h2;
        bus(1'b1, 8'h14, 32'hf0);
        bus(1'b1, 8'h18, 32'h0f);
        bus(1'b1, 8'h34, 32'h09);
        bus(1'b0, 8'h1c, 32'h0);
        check("port_a_in", rd, 32'ha3);
        bus(1'b0, 8'h2c, 32'h0);
        check("port_b_in", rd, 32'h2);
        check("port_pins", {a_drv, a_oe, a_pull, b_oe, b_drv}, {8'ha5, 8'hf0, 8'h0f, 4'hc, 4'h0});
        check("port_c_ctl", {b_pull, c_oe, c_pull}, {4'h0, 6'h01, 6'h36});
        @(posedge clk_sys_i);
        c_val <= 6'h00;
        #1;
        check("pin_reset", {chip_rst, a_oe, a_pull, b_oe, c_oe}, {1'b1, 26'h0});
        repeat (4) @(posedge clk_sys_i);
        c_val <= 6'h08;
        bus(1'b0, 8'h14, 32'h0);
        check("dir_after_reset", {chip_rst, rd[30:0]}, 32'h0);
        @(posedge clk_sys_i);
        fuse <= 1'b0;
        @(posedge clk_sys_i);
        c_val <= 6'h00;
        bus(1'b1, 8'h34, 32'h08);
        bus(1'b1, 8'h30, 32'h08);
        bus(1'b0, 8'h04, 32'h0);
        check("gpio_mode", {chip_rst, rd[30:0]}, 32'h10);
        check("gpio_drive", {26'h0, c_oe & c_drv}, 32'h08);
        bus(1'b1, 8'h10, 32'h3c);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 8'h00, {28'h0, MODE[i], 1'b1});
            sleep_pulse();
            check("sleep", {state, cpu_en, io_en, adc_en, osc_en}, {ST[i], EN[i]});
            @(posedge clk_sys_i);
            wake_irq <= 1'b1;
            @(posedge clk_sys_i);
            wake_irq <= 1'b0;
            #1;
            check("wake", {state, cpu_en, io_en, adc_en, osc_en}, {3'h0, 4'hf});
        end
        bus(1'b0, 8'h10, 32'h0);
        check("kept_out", rd, 32'h3c);
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, 8'h00, (i == 0) ? 32'h4 : 32'h7);
            sleep_pulse();
            check("no_sleep", {29'h0, state}, 32'h0);
        end
        bus(1'b1, 8'h00, 32'h1);
        @(posedge clk_sys_i);
        ce <= 1'b0;
        sleep_pulse();
        check("ce_freeze", {hreadyout, state}, 4'h0);
        @(posedge clk_sys_i);
        ce <= 1'b1;
        sleep_pulse();
        check("ce_resume", {29'h0, state}, 32'h1);
        finish_test();
    end
endmodule // reset_pin_and_sleep_control_bench
`default_nettype wire
